// ### core/bus_master_regs.vh
// timing counts and field positions for the bus cycle master
`ifndef BUS_MASTER_REGS_VH
`define BUS_MASTER_REGS_VH

// clock period in ns
`define CLK_PERIOD_NS        10
// address setup before cycle frame, ns
`define ADDR_SETUP_NS        75
`define ADDR_SETUP_CYC       ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// address hold after cycle frame, ns
`define ADDR_HOLD_NS         25
`define ADDR_HOLD_CYC        ((`ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// frame to strobe / frame to write data, ns
`define FRAME_TO_STROBE_NS   100
`define FRAME_TO_STROBE_CYC  ((`FRAME_TO_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// write data stable to write strobe, ns
`define DATA_TO_STROBE_NS    100
`define DATA_TO_STROBE_CYC   ((`DATA_TO_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reply to read sample and read strobe release, ns
`define READ_DESKEW_NS       200
`define READ_DESKEW_CYC      ((`READ_DESKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reply to write strobe release, ns
`define WRITE_HOLD_NS        150
`define WRITE_HOLD_CYC       ((`WRITE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// data hold after write strobe release, ns
`define DATA_HOLD_NS         100
`define DATA_HOLD_CYC        ((`DATA_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// frame hold after write strobe release, ns
`define FRAME_HOLD_NS        175
`define FRAME_HOLD_CYC       ((`FRAME_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reply negation to write strobe in read-modify-write, ns
`define RMW_GAP_NS           200
`define RMW_GAP_CYC          ((`RMW_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// frame idle time, ns
`define FRAME_IDLE_NS        200
`define FRAME_IDLE_CYC       ((`FRAME_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reply negation to next frame, ns
`define REPLY_TO_FRAME_NS    300
`define REPLY_TO_FRAME_CYC   ((`REPLY_TO_FRAME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reply timeout, ns (10 us)
`define TIMEOUT_NS           10000
`define TIMEOUT_CYC          ((`TIMEOUT_NS) / `CLK_PERIOD_NS)

// cycle kinds on the command port
`define KIND_READ            3'h0
`define KIND_WRITE           3'h1
`define KIND_WRITE_BYTE      3'h2
`define KIND_RMW             3'h3
`define KIND_RMW_BYTE        3'h4

// line positions
`define LINE_PAR_FORCE       16
`define LINE_PAR_ERR_HI      17
`define LINE_BYTE_SEL        0

`endif

// ### core/pin_sync.v
// two flip-flop synchroniser for the incoming bus lines
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,      // system clock
    input  wire             reset_n,  // synchronous reset, active low
    input  wire [WIDTH-1:0] din,      // asynchronous levels
    output reg  [WIDTH-1:0] dout      // synchronised levels
);
    reg [WIDTH-1:0] stage1;

    // ****************************************
    // two stages, first read only by second
    // ****************************************
    always @(posedge clk) begin
        if (!reset_n) begin
            stage1 <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // pin_sync

// ### core/bus_master.v
// bus master driving single data transfer cycles on the muxed backplane
`timescale 1ns/1ps
`include "bus_master_regs.vh"
module bus_master #(
    parameter TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    input  wire        clk,            // system clock
    input  wire        reset_n,        // synchronous reset, active low
    input  wire        cmd_valid,      // request a cycle
    output wire        cmd_ready,      // idle, request taken
    input  wire [2:0]  cmd_kind,       // cycle kind
    input  wire [21:0] cmd_addr,       // address
    input  wire        cmd_io_page,    // address lies in io page
    input  wire [15:0] cmd_wdata,      // write data
    input  wire        cmd_force_par,  // write a forced parity error
    input  wire        bus_granted,    // mastership held
    output reg         done,           // cycle ended, one pulse
    output reg         timed_out,      // cycle aborted, with done; a write timeout also pulses it once without done
    output reg  [15:0] rd_data,        // read data
    output reg  [1:0]  rd_parity,      // parity error lines
    input  wire [21:0] dal_in_n,       // address/data lines seen
    output reg  [21:0] dal_out_n,      // address/data drive value
    output reg  [21:0] dal_oe,         // address/data drive enable
    input  wire        frame_in_n,     // cycle_frame seen
    output wire        frame_out_n,    // cycle_frame drive value
    output reg         frame_oe,       // cycle_frame enable
    output wire        read_out_n,     // read_strobe drive value
    output reg         read_oe,        // read_strobe enable
    output wire        write_out_n,    // write_strobe drive value
    output reg         write_oe,       // write_strobe enable
    output wire        wbc_out_n,      // write_byte_control drive value
    output reg         wbc_oe,         // write_byte_control enable
    output wire        iops_out_n,     // io_page_select drive value
    output reg         iops_oe,        // io_page_select enable
    input  wire        reply_in_n      // slave_reply seen
);
    localparam S_IDLE    = 4'h0;
    localparam S_ADDR    = 4'h1;
    localparam S_AHOLD   = 4'h2;
    localparam S_RWAIT   = 4'h3;
    localparam S_RREPLY  = 4'h4;
    localparam S_RDROP   = 4'h5;
    localparam S_WDATA   = 4'h6;
    localparam S_WWAIT   = 4'h7;
    localparam S_WREPLY  = 4'h8;
    localparam S_WDROP   = 4'h9;
    localparam S_WHOLD   = 4'hA;
    localparam S_END     = 4'hB;

    reg  [3:0]  state;
    reg  [15:0] cnt;
    reg  [15:0] idle_cnt;
    reg  [15:0] since_reply;
    reg  [2:0]  kind;
    reg  [15:0] wdata;
    wire [21:0] dal_s;
    wire        frame_s;
    wire        reply_s;
    wire        is_write;
    wire        is_byte;
    wire        is_rmw;
    wire        bus_quiet;

    // ****************************************
    // input synchronisers, lines inverted to active high
    // ****************************************
    pin_sync #(.WIDTH(24)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     ({~dal_in_n, ~frame_in_n, ~reply_in_n}),
        .dout    ({dal_s, frame_s, reply_s})
    );

    // open collector: drive low only while enabled
    assign frame_out_n = 1'b0;
    assign read_out_n  = 1'b0;
    assign write_out_n = 1'b0;
    assign wbc_out_n   = 1'b0;
    assign iops_out_n  = 1'b0;

    // cycle decode
    assign is_write  = (kind == `KIND_WRITE) || (kind == `KIND_WRITE_BYTE);
    assign is_byte   = (kind == `KIND_WRITE_BYTE) || (kind == `KIND_RMW_BYTE);
    assign is_rmw    = (kind == `KIND_RMW) || (kind == `KIND_RMW_BYTE);
    assign bus_quiet = !frame_s && (idle_cnt >= `FRAME_IDLE_CYC)
                       && (since_reply >= `REPLY_TO_FRAME_CYC);
    assign cmd_ready = (state == S_IDLE) && bus_granted && bus_quiet;

    // ****************************************
    // spacing counters for frame and reply idle
    // ****************************************
    always @(posedge clk) begin
        if (!reset_n) begin
            idle_cnt    <= 16'h0000;
            since_reply <= 16'h0000;
        end else begin
            if (frame_oe || frame_s)
                idle_cnt <= 16'h0000;
            else if (idle_cnt != 16'hFFFF)
                idle_cnt <= idle_cnt + 16'h0001;
            if (reply_s)
                since_reply <= 16'h0000;
            else if (since_reply != 16'hFFFF)
                since_reply <= since_reply + 16'h0001;
        end
    end

    // ****************************************
    // cycle sequencer
    // ****************************************
    always @(posedge clk) begin
        if (!reset_n) begin
            state     <= S_IDLE;
            cnt       <= 16'h0000;
            kind      <= `KIND_READ;
            wdata     <= 16'h0000;
            done      <= 1'b0;
            timed_out <= 1'b0;
            rd_data   <= 16'h0000;
            rd_parity <= 2'h0;
            dal_out_n <= 22'h3FFFFF;
            dal_oe    <= 22'h000000;
            frame_oe  <= 1'b0;
            read_oe   <= 1'b0;
            write_oe  <= 1'b0;
            wbc_oe    <= 1'b0;
            iops_oe   <= 1'b0;
        end else begin
            done      <= 1'b0;
            timed_out <= 1'b0;
            cnt       <= cnt + 16'h0001;
            case (state)
                S_IDLE: begin
                    cnt <= 16'h0000;
                    if (cmd_valid && cmd_ready) begin
                        kind      <= cmd_kind;
                        wdata     <= cmd_wdata;
                        // line 16 carries the address on reads and read-modify-writes, forced parity on plain and byte writes
                        dal_out_n <= ~{cmd_addr[21:17],
                                       ((cmd_kind == `KIND_WRITE ||
                                         cmd_kind == `KIND_WRITE_BYTE) ?
                                           cmd_force_par : cmd_addr[16]),
                                       cmd_addr[15:0]};
                        dal_oe    <= 22'h3FFFFF;
                        iops_oe   <= cmd_io_page;
                        wbc_oe    <= (cmd_kind == `KIND_WRITE) ||
                                     (cmd_kind == `KIND_WRITE_BYTE);
                        state     <= S_ADDR;
                    end
                end
                S_ADDR: if (cnt >= `ADDR_SETUP_CYC - 1) begin
                    frame_oe <= 1'b1;
                    cnt      <= 16'h0000;
                    state    <= S_AHOLD;
                end
                S_AHOLD: if (cnt >= `ADDR_HOLD_CYC - 1) begin
                    dal_oe  <= 22'h000000;
                    iops_oe <= 1'b0;
                    wbc_oe  <= 1'b0;
                    state   <= is_write ? S_WDATA : S_RWAIT;
                end
                S_RWAIT: if (cnt >= `FRAME_TO_STROBE_CYC - 1) begin
                    read_oe <= 1'b1;
                    cnt     <= 16'h0000;
                    state   <= S_RREPLY;
                end
                S_RREPLY: begin
                    if (!reply_s && cnt >= TIMEOUT_CYCLES - 1) begin
                        read_oe   <= 1'b0;
                        frame_oe  <= 1'b0;
                        done      <= 1'b1;
                        timed_out <= 1'b1;
                        state     <= S_END;
                    end else if (!reply_s) begin
                        cnt <= cnt + 16'h0001;
                    end else if (cnt[15] == 1'b0) begin
                        cnt <= 16'h8000;                              // reply seen, restart
                    end else if (cnt >= 16'h8000 + `READ_DESKEW_CYC - 1) begin
                        rd_data   <= dal_s[15:0];
                        rd_parity <= dal_s[`LINE_PAR_ERR_HI:`LINE_PAR_FORCE];
                        read_oe   <= 1'b0;
                        state     <= S_RDROP;
                    end
                end
                S_RDROP: if (!reply_s) begin
                    cnt <= 16'h0000;
                    if (is_rmw) begin
                        wbc_oe    <= is_byte;
                        dal_out_n <= {6'h3F, ~wdata};
                        dal_oe    <= 22'h00FFFF;
                        state     <= S_WWAIT;
                    end else begin
                        frame_oe <= 1'b0;
                        done     <= 1'b1;
                        state    <= S_END;
                    end
                end
                S_WDATA: if (cnt >= `FRAME_TO_STROBE_CYC - 1) begin
                    dal_out_n <= {6'h3F, ~wdata};
                    dal_oe    <= 22'h00FFFF;
                    wbc_oe    <= is_byte;
                    cnt       <= 16'h0000;
                    state     <= S_WWAIT;
                end
                S_WWAIT: if (cnt >= (is_rmw ? `RMW_GAP_CYC : `DATA_TO_STROBE_CYC) - 1)
                begin
                    write_oe <= 1'b1;
                    cnt      <= 16'h0000;
                    state    <= S_WREPLY;
                end
                S_WREPLY: begin
                    if (!reply_s && cnt >= TIMEOUT_CYCLES - 1) begin
                        write_oe  <= 1'b0;
                        timed_out <= 1'b1;
                        cnt       <= 16'h0000;
                        state     <= S_WHOLD;
                    end else if (!reply_s) begin
                        cnt <= cnt + 16'h0001;
                    end else if (cnt[15] == 1'b0) begin
                        cnt <= 16'h8000;
                    end else if (cnt >= 16'h8000 + `WRITE_HOLD_CYC - 1) begin
                        write_oe <= 1'b0;
                        cnt      <= 16'h0000;
                        state    <= S_WDROP;
                    end
                end
                S_WDROP: begin
                    if (cnt >= `DATA_HOLD_CYC - 1)
                        dal_oe <= 22'h000000;
                    if (!reply_s && cnt >= `FRAME_HOLD_CYC - 1) begin
                        dal_oe   <= 22'h000000;
                        wbc_oe   <= 1'b0;
                        frame_oe <= 1'b0;
                        done     <= 1'b1;
                        state    <= S_END;
                    end
                end
                S_WHOLD: if (cnt >= `FRAME_HOLD_CYC - 1) begin       // timeout end
                    dal_oe    <= 22'h000000;
                    wbc_oe    <= 1'b0;
                    frame_oe  <= 1'b0;
                    done      <= 1'b1;
                    timed_out <= 1'b1;
                    state     <= S_END;
                end
                S_END: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // bus_master

// ### sim/bus_master_asserts.sv
// checker for the bus cycle master
`timescale 1ns/1ps
module bus_master_asserts #(
    parameter TIMEOUT_CYCLES = 1000
) (
    input wire        clk,        // clock
    input wire        reset_n,    // reset
    input wire [21:0] dal_oe,     // lines enable
    input wire        frame_oe,   // frame enable
    input wire        read_oe,    // read enable
    input wire        write_oe,   // write enable
    input wire        timed_out,  // abort pulse
    input wire        reply_in_n  // reply seen
);
    reg [7:0] idle_cnt;   // frame idle cycles
    reg [7:0] quiet_cnt;  // reply idle cycles
    reg [7:0] rply_cnt;   // reply active cycles
    reg [7:0] woff_cnt;   // cycles since write strobe release

    // saturating idle and reply activity counters
    always @(posedge clk) begin
        if (!reset_n) begin
            idle_cnt  <= 8'h00;
            quiet_cnt <= 8'h00;
            rply_cnt  <= 8'h00;
            woff_cnt  <= 8'hFF;
        end else begin
            idle_cnt  <= frame_oe ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hFF};
            quiet_cnt <= !reply_in_n ? 8'h00 : quiet_cnt + {7'h00, quiet_cnt != 8'hFF};
            rply_cnt  <= reply_in_n ? 8'h00 : rply_cnt + {7'h00, rply_cnt != 8'hFF};
            woff_cnt  <= write_oe ? 8'h00 : woff_cnt + {7'h00, woff_cnt != 8'hFF};
        end
    end

    default clocking dflt @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_addr_setup;
        $rose(frame_oe) |-> dal_oe[21] && $past(dal_oe[21], 8);
    endproperty
    a_addr_setup: assert property (p_addr_setup)
        else $error("address setup short");
    property p_addr_hold;
        $rose(frame_oe) |-> dal_oe[21] [*3];
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address hold short");
    property p_read_delay;
        $rose(read_oe) |-> frame_oe && $past(frame_oe, 10);
    endproperty
    a_read_delay: assert property (p_read_delay)
        else $error("read strobe early");
    property p_read_release;
        $fell(read_oe) && !reply_in_n |-> rply_cnt >= 8'h14;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("read strobe released early");
    property p_read_window;
        $fell(reply_in_n) && read_oe |-> ##[1:200] !read_oe;
    endproperty
    a_read_window: assert property (p_read_window)
        else $error("read strobe held too long");
    property p_frame_stall;
        frame_oe && !reply_in_n |=> frame_oe;
    endproperty
    a_frame_stall: assert property (p_frame_stall)
        else $error("frame dropped under reply");
    property p_frame_idle;
        $rose(frame_oe) |-> idle_cnt >= 20 && quiet_cnt >= 30;
    endproperty
    a_frame_idle: assert property (p_frame_idle)
        else $error("frame spacing short");
    property p_write_setup;
        $rose(write_oe) |-> $past(dal_oe[0], 10) && quiet_cnt >= 20;
    endproperty
    a_write_setup: assert property (p_write_setup)
        else $error("write strobe early");
    property p_write_release;
        $fell(write_oe) && !timed_out |-> $past(reply_in_n, 15) == 1'b0;
    endproperty
    a_write_release: assert property (p_write_release)
        else $error("write hold short");
    property p_data_hold;
        !write_oe && woff_cnt < 8'h0A |-> dal_oe[0];
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data released early");
    property p_frame_hold;
        !write_oe && woff_cnt < 8'h12 |-> frame_oe;
    endproperty
    a_frame_hold: assert property (p_frame_hold)
        else $error("frame released early after write");
endmodule // bus_master_asserts

bind bus_master bus_master_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) bus_master_asserts_i (
    .clk(clk), .reset_n(reset_n), .dal_oe(dal_oe), .frame_oe(frame_oe),
    .read_oe(read_oe), .write_oe(write_oe), .timed_out(timed_out),
    .reply_in_n(reply_in_n));

// ### sim/bus_slave_model.sv
// behavioural slave: word store plus an io page block
`timescale 1ns/1ps
module bus_slave_model #(
    parameter IO_OFFSET = 13'h1F00  // io block place, plain value
) (
    input  wire [21:0] dal_n,     // data lines
    input  wire        frame_n,   // frame
    input  wire        read_n,    // read strobe
    input  wire        write_n,   // write strobe
    input  wire        wbc_n,     // byte control
    input  wire        iops_n,    // io select
    input  wire [15:0] reply_ns,  // reply delay
    input  wire [15:0] stall_ns,  // reply hold
    output reg         reply_on,  // reply pulled
    output reg         sl_oe,     // data driven
    output reg  [17:0] sl_data    // data value
);
    reg [15:0] mem [0:15];  // word store
    reg [15:0] bad;         // forced parity marks
    reg [21:0] adr;         // latched address
    reg        wr_addr;     // write announced
    reg        sel;         // selected
    wire [3:0] idx = adr[4:1];

    // idle state
    initial begin
        {reply_on, sl_oe, sel, wr_addr} = 4'h0;
        sl_data = 18'h00000;
        bad = 16'h0000;
        adr = 22'h000000;
    end
    // latch address on frame, deselect at frame end
    always @(negedge frame_n) begin
        adr = ~dal_n;
        wr_addr = ~wbc_n;
        sel = ~iops_n ? (adr[12:0] == IO_OFFSET) : 1'b1;
    end
    always @(posedge frame_n) sel = 1'b0;
    // read reply with data and parity marks
    always @(negedge read_n) if (sel) begin
        #(reply_ns);
        sl_data = {bad[idx], bad[idx], mem[idx]};
        sl_oe = 1'b1;
        reply_on = 1'b1;
    end
    // reply released before data
    always @(posedge read_n) if (reply_on) begin
        #(stall_ns) reply_on = 1'b0;
        #20 sl_oe = 1'b0;
    end
    // write reply, data taken at strobe release
    always @(negedge write_n) if (sel) #(reply_ns) reply_on = 1'b1;
    always @(posedge write_n) if (reply_on) begin
        if (wbc_n) mem[idx] = ~dal_n[15:0];
        else if (adr[0]) mem[idx][15:8] = ~dal_n[15:8];
        else mem[idx][7:0] = ~dal_n[7:0];
        bad[idx] = adr[16];
        #(stall_ns) reply_on = 1'b0;
    end
endmodule // bus_slave_model

// ### sim/tb_top.sv
// bench: bus cycle master against the slave model
`timescale 1ns/1ps
`include "bus_master_regs.vh"
module tb_top;
    reg         clk, reset_n, cmd_valid, cmd_io_page, cmd_force_par, bus_granted;
    reg  [2:0]  cmd_kind;
    reg  [21:0] cmd_addr;
    reg  [15:0] cmd_wdata, reply_ns, stall_ns;
    wire        cmd_ready, done, timed_out, reply_on, sl_oe;
    wire        frame_oe, read_oe, write_oe, wbc_oe, iops_oe;
    wire        frame_out_n, read_out_n, write_out_n, wbc_out_n, iops_out_n;
    wire        frame_n, read_n, write_n, wbc_n, iops_n;
    wire [1:0]  rd_parity;
    wire [15:0] rd_data;
    wire [17:0] sl_data;
    wire [21:0] dal_out_n, dal_oe, dal_n;
    integer     num_errors, checked;

    // open collector lines with pull-ups
    assign frame_n = frame_oe ? frame_out_n : 1'b1;
    assign read_n = read_oe ? read_out_n : 1'b1;
    assign write_n = write_oe ? write_out_n : 1'b1;
    assign wbc_n = wbc_oe ? wbc_out_n : 1'b1;
    assign iops_n = iops_oe ? iops_out_n : 1'b1;
    assign dal_n = ~((dal_oe & ~dal_out_n) | {4'h0, sl_oe ? sl_data : 18'h00000});

    bus_master #(.TIMEOUT_CYCLES(50)) bus_master_i (
        .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_io_page(cmd_io_page),
        .cmd_wdata(cmd_wdata), .cmd_force_par(cmd_force_par), .bus_granted(bus_granted),
        .done(done), .timed_out(timed_out), .rd_data(rd_data), .rd_parity(rd_parity),
        .dal_in_n(dal_n), .dal_out_n(dal_out_n), .dal_oe(dal_oe), .frame_in_n(frame_n),
        .frame_out_n(frame_out_n), .frame_oe(frame_oe), .read_out_n(read_out_n),
        .read_oe(read_oe), .write_out_n(write_out_n), .write_oe(write_oe),
        .wbc_out_n(wbc_out_n), .wbc_oe(wbc_oe), .iops_out_n(iops_out_n),
        .iops_oe(iops_oe), .reply_in_n(~reply_on));
    bus_slave_model bus_slave_model_i (
        .dal_n(dal_n), .frame_n(frame_n), .read_n(read_n), .write_n(write_n),
        .wbc_n(wbc_n), .iops_n(iops_n), .reply_ns(reply_ns), .stall_ns(stall_ns),
        .reply_on(reply_on), .sl_oe(sl_oe), .sl_data(sl_data));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task tick;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task check(input [17:0] got, input [17:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // one bus cycle: wait ready, hand over, wait end
    task run(input [2:0] k, input [21:0] a, input io, input [15:0] wd, input fp);
        integer n;
        begin
            {cmd_kind, cmd_addr, cmd_io_page, cmd_wdata, cmd_force_par} = {k, a, io, wd, fp};
            cmd_valid = 1'b1;
            n = 0;
            while (cmd_ready !== 1'b1 && n < 500) begin
                tick;
                n = n + 1;
            end
            tick;
            cmd_valid = 1'b0;
            while (done !== 1'b1 && n < 3000) begin
                tick;
                n = n + 1;
            end
            if (n >= 3000) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED at %0t: cycle never ended", $time);
                test_done;
            end
        end
    endtask

    task t_word;
        begin
            bus_granted = 1'b0;
            repeat (60) tick;
            check({17'h00000, cmd_ready}, 18'h00000);
            bus_granted = 1'b1;
            run(`KIND_WRITE, 22'h2A0004, 1'b0, 16'hC35A, 1'b0);
            check({17'h00000, bus_slave_model_i.wr_addr}, 18'h00001);
            run(`KIND_READ, 22'h2A0004, 1'b0, 16'h0000, 1'b0);
            check({rd_parity, rd_data}, 18'h0C35A);
            check({17'h00000, bus_slave_model_i.wr_addr}, 18'h00000);
            $display("test word done");
        end
    endtask
    task t_byte_rmw;
        begin
            run(`KIND_WRITE, 22'h000006, 1'b0, 16'h1234, 1'b0);
            run(`KIND_WRITE_BYTE, 22'h000007, 1'b0, 16'hABFF, 1'b0);
            run(`KIND_WRITE_BYTE, 22'h000006, 1'b0, 16'hEECD, 1'b0);
            run(`KIND_RMW, 22'h000006, 1'b0, 16'h5555, 1'b0);
            check({2'h0, rd_data}, 18'h0ABCD);
            run(`KIND_RMW_BYTE, 22'h000007, 1'b0, 16'h99EE, 1'b0);
            check({2'h0, rd_data}, 18'h05555);
            run(`KIND_READ, 22'h000006, 1'b0, 16'h0000, 1'b0);
            check({2'h0, rd_data}, 18'h09955);
            $display("test byte and rmw done");
        end
    endtask
    task t_parity_io;
        begin
            run(`KIND_WRITE, 22'h000008, 1'b0, 16'h0F0F, 1'b1);
            run(`KIND_READ, 22'h000008, 1'b0, 16'h0000, 1'b0);
            check({rd_parity, rd_data}, 18'h30F0F);
            run(`KIND_WRITE, 22'h3FFF00, 1'b1, 16'h7E81, 1'b0);
            run(`KIND_READ, 22'h001F00, 1'b1, 16'h0000, 1'b0);
            check({1'b0, timed_out, rd_data}, 18'h07E81);
            run(`KIND_READ, 22'h000010, 1'b1, 16'h0000, 1'b0);
            check({1'b0, timed_out, rd_data}, 18'h17E81);
            $display("test parity and io done");
        end
    endtask
    task t_slow;
        begin
            reply_ns = 16'h012C;
            stall_ns = 16'h0190;
            run(`KIND_WRITE, 22'h000008, 1'b0, 16'h2468, 1'b0);
            run(`KIND_READ, 22'h000008, 1'b0, 16'h0000, 1'b0);
            check({rd_parity, rd_data}, 18'h02468);
            $display("test slow slave done");
        end
    endtask

    // main sequence
    initial begin
        num_errors = 0;
        checked = 0;
        {reset_n, cmd_valid, cmd_io_page, cmd_force_par, bus_granted} = 5'h01;
        {cmd_kind, cmd_addr, cmd_wdata} = 41'h00000000000;
        reply_ns = 16'h0014;
        stall_ns = 16'h0000;
        repeat (10) tick;
        check({14'h0000, frame_oe, read_oe, write_oe, done}, 18'h00000);
        check({2'h0, rd_data}, 18'h00000);
        reset_n = 1'b1;
        t_word;
        t_byte_rmw;
        t_parity_io;
        t_slow;
        test_done;
    end
endmodule // tb_top
